/* pkg/cspb_defs.svh */
`ifndef CSPB_DEFS_SVH
`define CSPB_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CSPB_OFF_LEVEL    5'h00
`define CSPB_OFF_CHANGE   5'h04
`define CSPB_OFF_CLEAR    5'h08
`define CSPB_OFF_ENABLE   5'h0C
`define CSPB_OFF_GCR_A    5'h10
`define CSPB_OFF_GCR_B    5'h14
`define CSPB_OFF_ACCESS   5'h18
// ---------------------------------------------------------------
// widths, fields and reset values
// ---------------------------------------------------------------
`define CSPB_ADDR_W       5
`define CSPB_PORT_W       8
`define CSPB_OUT_W        4
`define CSPB_GCR_W        2
`define CSPB_PORT_RST     8'h00
`define CSPB_GCR_RST      2'h0
`define CSPB_ACC_BUSY     0
`define CSPB_ACC_WIDE     1
`define CSPB_LANE0        0
`endif

/* pkg/cspb_pkg.sv */
package cspb_pkg;
   // ------------------------------------------------------------
   // socket b access sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CSPB_IDLE    = 2'b00,  // no access in progress
      CSPB_STROBE  = 2'b01,  // address latch strobe high
      CSPB_WAITING = 2'b10,  // waiting for card wait release
      CSPB_DONE    = 2'b11   // completion pulse
   } cspb_state_t;
endpackage

/* rtl/cspb_top.sv */
// Functional notes
// - strobe address latch at each socket b access
// - input lines 0-1 reported in level/change regs
// - input lines 2-7 reported in level/change regs
// - io access samples wide-port input
// - output lines 0-1 follow socket a control
// - output lines 2-3 follow socket b control
// - access completes only after wait released
`timescale 1ns/1ps
`default_nettype none
`include "cspb_defs.svh"

module cspb_top (
   input  wire logic                    core_clk_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    ce_i,
   // avalon-mm slave
   input  wire logic [`CSPB_ADDR_W-1:0] avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   input  wire logic [3:0]              avs_byteenable_i,
   output logic      [31:0]             avs_readdata_o,
   output logic                         avs_waitrequest_o,
   output logic                         irq_o,
   // socket b access requests
   input  wire logic                    access_req_i,
   input  wire logic                    access_io_i,
   output logic                         access_done_o,
   output logic                         access_wide_o,
   // card pins
   input  wire logic [`CSPB_PORT_W-1:0] socket_b_input_port_i,
   input  wire logic                    socket_b_io_is_wide_i,
   input  wire logic                    socket_b_wait_n_i,
   output logic                         socket_b_addr_latch_o,
   output logic      [`CSPB_OUT_W-1:0]  card_output_port_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [`CSPB_PORT_W-1:0] sync1_r;          // first sync stage
   logic [`CSPB_PORT_W-1:0] sync2_r;          // second sync stage
   logic [`CSPB_PORT_W-1:0] card_pin_level_reg_r;  // previous sample
   logic [`CSPB_PORT_W-1:0] card_pin_change_reg_r; // sticky changes
   logic [`CSPB_PORT_W-1:0] irq_enable_r;     // interrupt enables
   logic [`CSPB_PORT_W-1:0] pin_edge;         // level transition
   logic [`CSPB_PORT_W-1:0] clear_mask;       // clear from software
   logic [`CSPB_GCR_W-1:0]  socket_a_general_ctrl_reg_r;
   logic [`CSPB_GCR_W-1:0]  socket_b_general_ctrl_reg_r;
   cspb_pkg::cspb_state_t   state_r;          // access sequencer
   logic                    io_access_r;      // current access is io
   logic                    wide_r;           // last access port width
   logic                    ale_r;            // address latch flop
   logic                    done_r;           // completion flop
   logic                    wreq_r;           // waitrequest flop
   logic [31:0]             rdata_r;          // read data flop
   logic                    irq_r;            // interrupt flop
   logic                    wr_take;          // write accepted
   logic                    rd_first;         // read first seen
   logic                    lane0;            // low byte enabled

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // match a bus address against a register offset
   function automatic logic hit(input logic [`CSPB_ADDR_W-1:0] a,
                                input logic [`CSPB_ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   // ------------------------------------------------------------
   // bus strobes
   // ------------------------------------------------------------
   // write lands at the edge where waitrequest is low
   assign wr_take  = ce_i & avs_write_i & ~wreq_r;
   assign rd_first = ce_i & avs_read_i & wreq_r;
   assign lane0    = avs_byteenable_i[`CSPB_LANE0];
   assign clear_mask = (wr_take & lane0 &
                        hit(avs_address_i, `CSPB_OFF_CLEAR)) ?
                       avs_writedata_i[`CSPB_PORT_W-1:0] :
                       `CSPB_PORT_RST;

   // ------------------------------------------------------------
   // input port synchroniser and change detect
   // ------------------------------------------------------------
   // two flops, then a third holding the previous settled level
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_r              <= `CSPB_PORT_RST;
         sync2_r              <= `CSPB_PORT_RST;
         card_pin_level_reg_r <= `CSPB_PORT_RST;
      end else if (ce_i) begin
         sync1_r              <= socket_b_input_port_i;
         sync2_r              <= sync1_r;
         card_pin_level_reg_r <= sync2_r;
      end
   end

   // transition seen only between settled samples
   assign pin_edge = sync2_r ^ card_pin_level_reg_r;

   // sticky change flags; a new edge beats a clear
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         card_pin_change_reg_r <= `CSPB_PORT_RST;
      end else if (ce_i) begin
         card_pin_change_reg_r <= (card_pin_change_reg_r & ~clear_mask)
                                  | pin_edge;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // software writes to enable and general control registers
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_enable_r                <= `CSPB_PORT_RST;
         socket_a_general_ctrl_reg_r <= `CSPB_GCR_RST;
         socket_b_general_ctrl_reg_r <= `CSPB_GCR_RST;
      end else if (wr_take && lane0) begin
         if (hit(avs_address_i, `CSPB_OFF_ENABLE)) begin
            irq_enable_r <= avs_writedata_i[`CSPB_PORT_W-1:0];
         end
         if (hit(avs_address_i, `CSPB_OFF_GCR_A)) begin
            socket_a_general_ctrl_reg_r <=
               avs_writedata_i[`CSPB_GCR_W-1:0];
         end
         if (hit(avs_address_i, `CSPB_OFF_GCR_B)) begin
            socket_b_general_ctrl_reg_r <=
               avs_writedata_i[`CSPB_GCR_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // avalon slave: one wait state, then answer
   // ------------------------------------------------------------
   // waitrequest drops for one cycle after a request is seen
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wreq_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (ce_i) begin
         if ((avs_read_i || avs_write_i) && wreq_r) begin
            wreq_r <= 1'b0;
         end else begin
            wreq_r <= 1'b1;
         end
         if (rd_first) begin
            // unmapped and write-only offsets read as zero
            rdata_r <= 32'h0000_0000;
            if (hit(avs_address_i, `CSPB_OFF_LEVEL)) begin
               rdata_r[`CSPB_PORT_W-1:0] <= card_pin_level_reg_r;
            end
            if (hit(avs_address_i, `CSPB_OFF_CHANGE)) begin
               rdata_r[`CSPB_PORT_W-1:0] <= card_pin_change_reg_r;
            end
            if (hit(avs_address_i, `CSPB_OFF_ENABLE)) begin
               rdata_r[`CSPB_PORT_W-1:0] <= irq_enable_r;
            end
            if (hit(avs_address_i, `CSPB_OFF_GCR_A)) begin
               rdata_r[`CSPB_GCR_W-1:0] <= socket_a_general_ctrl_reg_r;
            end
            if (hit(avs_address_i, `CSPB_OFF_GCR_B)) begin
               rdata_r[`CSPB_GCR_W-1:0] <= socket_b_general_ctrl_reg_r;
            end
            if (hit(avs_address_i, `CSPB_OFF_ACCESS)) begin
               rdata_r[`CSPB_ACC_BUSY] <=
                  (state_r != cspb_pkg::CSPB_IDLE);
               rdata_r[`CSPB_ACC_WIDE] <= wide_r;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   // level output while any enabled change flag is set
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_r <= 1'b0;
      end else if (ce_i) begin
         irq_r <= |(card_pin_change_reg_r & irq_enable_r);
      end
   end

   // ------------------------------------------------------------
   // socket b access sequencer
   // ------------------------------------------------------------
   // strobe, hold while card waits, then complete
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r     <= cspb_pkg::CSPB_IDLE;
         io_access_r <= 1'b0;
         wide_r      <= 1'b0;
         ale_r       <= 1'b0;
         done_r      <= 1'b0;
      end else if (ce_i) begin
         ale_r  <= 1'b0;
         done_r <= 1'b0;
         unique case (state_r)
            cspb_pkg::CSPB_IDLE: begin
               if (access_req_i) begin
                  state_r     <= cspb_pkg::CSPB_STROBE;
                  io_access_r <= access_io_i;
                  ale_r       <= 1'b1;
               end
            end
            cspb_pkg::CSPB_STROBE: begin
               state_r <= cspb_pkg::CSPB_WAITING;
            end
            cspb_pkg::CSPB_WAITING: begin
               // card holds wait low to stretch the access
               if (socket_b_wait_n_i) begin
                  state_r <= cspb_pkg::CSPB_DONE;
                  done_r  <= 1'b1;
                  // memory accesses report a narrow port
                  wide_r  <= io_access_r & socket_b_io_is_wide_i;
               end
            end
            cspb_pkg::CSPB_DONE: begin
               state_r <= cspb_pkg::CSPB_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign avs_readdata_o        = rdata_r;
   assign avs_waitrequest_o     = wreq_r;
   assign irq_o                 = irq_r;
   assign access_done_o         = done_r;
   assign access_wide_o         = wide_r;
   assign socket_b_addr_latch_o = ale_r;
   assign card_output_port_o    = {socket_b_general_ctrl_reg_r,
                                   socket_a_general_ctrl_reg_r};

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_ale_on_start;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i && access_req_i && state_r == cspb_pkg::CSPB_IDLE
      |=> socket_b_addr_latch_o ##1 !socket_b_addr_latch_o;
   endproperty
   a_ale_on_start: assert property (p_ale_on_start)
      else $error("address latch strobe missing");

   property p_level_low;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i && $past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3)
      |-> card_pin_level_reg_r[1:0] ==
          $past(socket_b_input_port_i[1:0], 3);
   endproperty
   a_level_low: assert property (p_level_low)
      else $error("low input level not reported");

   property p_change_high;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i && pin_edge[7:2] != 6'h00
      |=> (card_pin_change_reg_r[7:2] & $past(pin_edge[7:2])) ==
          $past(pin_edge[7:2]);
   endproperty
   a_change_high: assert property (p_change_high)
      else $error("input change not flagged");

   property p_wide_sample;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i && state_r == cspb_pkg::CSPB_WAITING && socket_b_wait_n_i
      |=> access_wide_o == ($past(io_access_r) &&
                            $past(socket_b_io_is_wide_i));
   endproperty
   a_wide_sample: assert property (p_wide_sample)
      else $error("port width not captured");

   property p_out_a;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_take && lane0 && avs_address_i == `CSPB_OFF_GCR_A
      |=> card_output_port_o[1:0] == $past(avs_writedata_i[1:0]);
   endproperty
   a_out_a: assert property (p_out_a)
      else $error("output lines 0-1 wrong");

   property p_out_b;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_take && lane0 && avs_address_i == `CSPB_OFF_GCR_B
      |=> card_output_port_o[3:2] == $past(avs_writedata_i[1:0]);
   endproperty
   a_out_b: assert property (p_out_b)
      else $error("output lines 2-3 wrong");

   property p_wait_hold;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i && state_r == cspb_pkg::CSPB_WAITING && !socket_b_wait_n_i
      |=> !access_done_o && state_r == cspb_pkg::CSPB_WAITING;
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("access completed during wait");

   property p_flag_cause;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ce_i |=> (card_pin_change_reg_r & ~$past(card_pin_change_reg_r)
                & ~$past(pin_edge)) == 8'h00;
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("change flag set without transition");

endmodule
`default_nettype wire

/* tb/cspb_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// card in socket b: input lines, port size, wait
// ---------------------------------------------------------------
module cspb_card_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ale_i,      // address latch strobe
   input  wire logic [7:0] pins_i,     // wanted input line levels
   input  wire logic       wide_i,     // card io port is 16 bits
   input  wire logic [3:0] wait_len_i, // wait cycles per access
   output logic      [7:0] port_o,
   output logic            wide_o,
   output logic            wait_n_o
);
   logic [3:0] wait_cnt_r; // remaining wait cycles

   // card drives its general lines as levels
   assign port_o = pins_i;
   assign wide_o = wide_i;

   // hold wait low for the chosen count after each strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_cnt_r <= 4'h0;
      end else if (ale_i) begin
         wait_cnt_r <= wait_len_i;
      end else if (wait_cnt_r != 4'h0) begin
         wait_cnt_r <= wait_cnt_r - 4'h1;
      end
   end
   assign wait_n_o = (wait_cnt_r == 4'h0);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cspb_defs.svh"
module tb_top;
   logic        clk, rst_n, rd, wr, irq, req, io, done, wide_o;
   logic        wreq, iowide, wait_n, ale, wide_in;
   logic [4:0]  addr;       // register byte address
   logic [31:0] wdata, rdata, q;
   logic [3:0]  be, outp, wait_len;
   logic [7:0]  port, pins;
   int          error_cnt, checked, cyc, ale_cnt, done_cnt, ale_cyc;
   int          done_cyc, m_lvl, m_chg, k, seed_v;
   logic [1:0]  va, vb;     // control register values

   cspb_top DUT (.core_clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .irq_o(irq),
      .access_req_i(req), .access_io_i(io), .access_done_o(done),
      .access_wide_o(wide_o), .socket_b_input_port_i(port),
      .socket_b_io_is_wide_i(iowide), .socket_b_wait_n_i(wait_n),
      .socket_b_addr_latch_o(ale), .card_output_port_o(outp));
   cspb_card_model card (.clk_i(clk), .rst_n_i(rst_n), .ale_i(ale),
      .pins_i(pins), .wide_i(wide_in), .wait_len_i(wait_len),
      .port_o(port), .wide_o(iowide), .wait_n_o(wait_n));

   // ------------------------------------------------------------
   // clock, strobe monitor, helpers
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count strobe and done pulses, stamp their cycles
   always @(posedge clk) begin
      cyc++;
      if (ale === 1'b1) begin
         ale_cnt++;
         ale_cyc = cyc;
      end
      if (done === 1'b1) begin
         done_cnt++;
         done_cyc = cyc;
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t bus hang", $time);
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(q, e, "register read");
   endtask
   // move input lines, update level and change model
   task automatic pin_step(input logic [7:0] v);
      @(posedge clk);
      pins <= v;
      m_chg = m_chg | (m_lvl ^ v);
      m_lvl = v;
      repeat (5) @(posedge clk);
      rd_chk(`CSPB_OFF_LEVEL, m_lvl);
      rd_chk(`CSPB_OFF_CHANGE, m_chg);
   endtask
   // one socket b access, wait length nw
   task automatic access(input logic i, w, input logic [3:0] nw);
      int n;
      @(posedge clk);
      req <= 1'b1;
      io <= i;
      wide_in <= w;
      wait_len <= nw;
      ale_cnt = 0;
      done_cnt = 0;
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      while (done_cnt == 0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      // a missing completion ends the run as a mismatch
      if (n >= 40) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t access hang", $time);
         complete_run();
      end
      repeat (2) @(posedge clk);
      chk(ale_cnt, 1, "strobe count");
      chk(done_cnt, 1, "done count");
      chk(done_cyc - ale_cyc, nw + 2, "wait extension");
      chk(wide_o, i & w, "port size");
      rd_chk(`CSPB_OFF_ACCESS, {30'h0, i & w, 1'b0});
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rd, wr, req, io, wide_in} = 5'h00;
      {addr, wdata, be, wait_len, pins} = '0;
      rst_n = 1'b0;
      seed_v = $urandom(32'hD706);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(wreq, 1'b1, "idle waitrequest");
      chk(outp, 4'h0, "output reset");
      // reset values of all offsets, unmapped one included
      for (k = 0; k < 8; k++) rd_chk(5'(k * 4), 32'h0);
      // control registers onto output lines
      for (k = 0; k < 4; k++) begin
         va = 2'($urandom);
         vb = 2'($urandom);
         bus(1'b1, `CSPB_OFF_GCR_A, {30'h0, va}, 4'hF);
         bus(1'b1, `CSPB_OFF_GCR_B, {30'h0, vb}, 4'hF);
         bus(1'b1, `CSPB_OFF_GCR_A, {30'h0, ~va}, 4'h0);
         rd_chk(`CSPB_OFF_GCR_A, {30'h0, va});
         rd_chk(`CSPB_OFF_GCR_B, {30'h0, vb});
         chk(outp, {vb, va}, "output lines");
      end
      // input lines, change flags and interrupt
      for (k = 0; k < 5; k++) pin_step(8'($urandom));
      pin_step(~m_lvl[7:0]);
      chk(irq, 1'b0, "irq masked");
      bus(1'b1, `CSPB_OFF_ENABLE, 32'hFF, 4'hF);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1, "irq raised");
      bus(1'b1, `CSPB_OFF_CLEAR, 32'hFF, 4'hF);
      m_chg = 0;
      rd_chk(`CSPB_OFF_CHANGE, 32'h0);
      chk(irq, 1'b0, "irq cleared");
      bus(1'b1, `CSPB_OFF_ENABLE, 32'h01, 4'hF);
      pin_step(8'(m_lvl ^ 8'h80));
      chk(irq, 1'b0, "irq other bit masked");
      pin_step(8'(m_lvl ^ 8'h01));
      chk(irq, 1'b1, "irq enabled bit");
      // memory and io accesses, with and without wait
      for (k = 0; k < 8; k++)
         access(k[0], k[1], k[2] ? 4'(($urandom % 6) + 1) : 4'h0);
      complete_run();
   end
   // bound on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("CHECK FAILED t=%0t run too long", $time);
      complete_run();
   end
endmodule
`default_nettype wire
